// ==== rtl/oag_adder.sv ====
// index adder: ones-complement for words, sign-extended for characters
// purely combinational; the caller registers the result
`timescale 1ns/1ps
module oag_adder (
    // operands
    input  wire logic                          char_mode,
    input  wire logic [oag_pkg::CADDR_W-1:0]   base,
    input  wire logic [oag_pkg::WADDR_W-1:0]   index_val,
    // result
    output logic      [oag_pkg::CADDR_W-1:0]   sum
);
    import oag_pkg::*;

    function automatic logic [WADDR_W-1:0] ones_add(input logic [WADDR_W-1:0] a,
                                                    input logic [WADDR_W-1:0] b);
        logic [WADDR_W:0] raw;
        raw = {1'b0, a} + {1'b0, b};
        // end-around carry folds the overflow back in
        ones_add = raw[WADDR_W-1:0] + {{(WADDR_W-1){1'b0}}, raw[WADDR_W]};
    endfunction : ones_add

    always_comb begin
        if (char_mode)
            sum = base + {{(CADDR_W-WADDR_W){index_val[WADDR_W-1]}}, index_val};
        else
            sum = {2'b00, ones_add(base[WADDR_W-1:0], index_val)};
    end
endmodule : oag_adder

// ==== rtl/oag_index_sel.sv ====
// index register selection for designators and business-data flags
// assumes the three index registers are supplied by the register file
`timescale 1ns/1ps
module oag_index_sel (
    // selection
    input  wire logic                          bdp_flag_mode,
    input  wire logic [oag_pkg::DESIG_W-1:0]   sel,
    // index registers
    input  wire logic [oag_pkg::WADDR_W-1:0]   index1,
    input  wire logic [oag_pkg::WADDR_W-1:0]   index2,
    input  wire logic [oag_pkg::WADDR_W-1:0]   index3,
    // result
    output logic                               use_index,
    output logic      [oag_pkg::WADDR_W-1:0]   index_val
);
    import oag_pkg::*;
    always_comb begin
        use_index = (sel != 2'h0);
        index_val = 15'h0000;
        if (bdp_flag_mode) begin
            case (sel)
                2'h1, 2'h3: index_val = index1;
                2'h2:       index_val = index2;
                default:    index_val = 15'h0000;
            endcase
        end else begin
            case (sel)
                2'h1:    index_val = index1;
                2'h2:    index_val = index2;
                2'h3:    index_val = index3;
                default: index_val = 15'h0000;
            endcase
        end
    end
endmodule : oag_index_sel

// ==== rtl/oag_pkg.sv ====
// constants and types for operand address generation
// assumes one clock and core storage with a fixed-latency-free valid strobe
// Operation
// - two-bit designator picks one of three index registers; zero means no change
// - indexing adds the chosen index; character addresses sign-extend it to bit 16
// - business-data flags choose the index register instead of the designator
// - flag 1 or 3 picks index one, 2 picks index two, 0 none
// - mixed word/character forms add only the low 15 address bits
// - no-address mode takes operand directly, ignoring mode and designator bits
// - mode bit zero means the low field is the direct address
// - mode bit one on execution-address instructions fetches an address word
// - indirect fetches repeat until a fetched word has mode bit clear
// - indexing and indirection are independent steps, any combination allowed
// - each indirect step indexes, reads, then adopts address, mode, designator
// - fetched address replaces the held instruction copy only, never memory
// - instruction needing an absent optional module is trapped
// - after each instruction the next instruction fetch sequence runs
package oag_pkg;
    localparam int WORD_W   = 24;
    localparam int WADDR_W  = 15;
    localparam int CADDR_W  = 17;
    localparam int DESIG_W  = 2;
    // instruction field positions
    localparam int MODE_BIT  = 17;
    localparam int DESIG_LO  = 15;
    localparam int CMODE_BIT = 19;
    localparam int CDESIG_LO = 17;
    localparam logic [WORD_W-1:0] WORD_RST = 24'h000000;

    typedef enum logic [1:0] {
        OAG_FMT_NOADDR,
        OAG_FMT_WORD,
        OAG_FMT_CHAR,
        OAG_FMT_BDP
    } oag_fmt_t;

    typedef enum logic [2:0] {
        OAG_IDLE,
        OAG_INDEX,
        OAG_FETCH,
        OAG_WAIT,
        OAG_DONE,
        OAG_TRAP
    } oag_state_t;
endpackage : oag_pkg

// ==== rtl/oag_top.sv ====
// operand address generation: indexing, direct and multi-level indirect addressing
// assumes the sequencer holds start for one cycle and storage answers with rd_valid
`timescale 1ns/1ps
module oag_top (
    // clock and reset
    input  wire logic                          core_clk,
    input  wire logic                          rst_b,
    // instruction from the control sequence
    input  wire logic                          start,
    input  wire logic [oag_pkg::WORD_W-1:0]    instr,
    input  wire oag_pkg::oag_fmt_t             fmt,
    input  wire logic                          indirect_ok,
    input  wire logic [oag_pkg::DESIG_W-1:0]   bdp_flag,
    input  wire logic                          needs_option,
    input  wire logic                          option_present,
    input  wire logic                          instr_complete,
    // index registers
    input  wire logic [oag_pkg::WADDR_W-1:0]   index1,
    input  wire logic [oag_pkg::WADDR_W-1:0]   index2,
    input  wire logic [oag_pkg::WADDR_W-1:0]   index3,
    // core storage read port
    output logic                               rd_req,
    output logic      [oag_pkg::WADDR_W-1:0]   rd_addr,
    input  wire logic                          rd_valid,
    input  wire logic [oag_pkg::WORD_W-1:0]    rd_data,
    // results
    output logic                               busy,
    output logic                               done,
    output logic                               trap,
    output logic      [oag_pkg::CADDR_W-1:0]   operand_addr,
    output logic      [oag_pkg::WORD_W-1:0]    held_instr,
    output logic      [oag_pkg::WORD_W-1:0]    indirect_levels,
    output logic                               next_instruction_fetch_sequence
);
    import oag_pkg::*;

    oag_state_t              state;
    oag_fmt_t                cur_fmt;
    logic [CADDR_W-1:0]      addr;
    logic [DESIG_W-1:0]      desig;
    logic                    mode;
    logic                    use_index;
    logic [WADDR_W-1:0]      index_val;
    logic [CADDR_W-1:0]      sum;
    logic [DESIG_W-1:0]      sel;
    logic                    is_bdp;
    logic                    absent;
    logic                    take;

    assign is_bdp = (cur_fmt == OAG_FMT_BDP);
    assign sel    = is_bdp ? bdp_flag : desig;
    // a missing option overrides every other outcome of a start, no-address included
    assign absent = needs_option && !option_present;
    assign take   = (state == OAG_IDLE) && start;

    oag_index_sel u_sel (
        .bdp_flag_mode (is_bdp),
        .sel           (sel),
        .index1        (index1),
        .index2        (index2),
        .index3        (index3),
        .use_index     (use_index),
        .index_val     (index_val)
    );

    oag_adder u_add (
        .char_mode (cur_fmt == OAG_FMT_CHAR),
        .base      (addr),
        .index_val (index_val),
        .sum       (sum)
    );

    assign busy   = (state != OAG_IDLE);
    assign rd_req = (state == OAG_FETCH);

    // sequencing
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= OAG_IDLE;
        end else begin
            case (state)
                OAG_IDLE:
                    if (start) begin
                        if (absent)
                            state <= OAG_TRAP;
                        else if (fmt == OAG_FMT_NOADDR)
                            state <= OAG_DONE;
                        else
                            state <= OAG_INDEX;
                    end
                OAG_INDEX:
                    // indirection only on word-addressed execution-address forms
                    if (mode && cur_fmt == OAG_FMT_WORD && indirect_ok)
                        state <= OAG_FETCH;
                    else
                        state <= OAG_DONE;
                OAG_FETCH: state <= OAG_WAIT;
                OAG_WAIT:
                    if (rd_valid)
                        state <= OAG_INDEX;
                OAG_DONE, OAG_TRAP:
                    if (instr_complete)
                        state <= OAG_IDLE;
                default: state <= OAG_IDLE;
            endcase
        end
    end

    // working address, mode and designator
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            addr    <= 17'h00000;
            desig   <= 2'h0;
            mode    <= 1'b0;
            cur_fmt <= OAG_FMT_NOADDR;
        end else if (state == OAG_IDLE && start) begin
            cur_fmt <= fmt;
            case (fmt)
                OAG_FMT_CHAR: begin
                    addr  <= instr[CADDR_W-1:0];
                    desig <= instr[CDESIG_LO +: DESIG_W];
                    mode  <= 1'b0;
                end
                OAG_FMT_NOADDR: begin
                    addr  <= instr[CADDR_W-1:0];
                    desig <= 2'h0;
                    mode  <= 1'b0;
                end
                default: begin
                    addr  <= {2'b00, instr[WADDR_W-1:0]};
                    desig <= instr[DESIG_LO +: DESIG_W];
                    mode  <= instr[MODE_BIT];
                end
            endcase
        end else if (state == OAG_INDEX) begin
            if (use_index)
                addr <= sum;
        end else if (state == OAG_WAIT && rd_valid) begin
            addr  <= {2'b00, rd_data[WADDR_W-1:0]};
            desig <= rd_data[DESIG_LO +: DESIG_W];
            mode  <= rd_data[MODE_BIT];
        end
    end

    // storage address for the indirect read
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            rd_addr <= 15'h0000;
        else if (state == OAG_INDEX)
            rd_addr <= use_index ? sum[WADDR_W-1:0] : addr[WADDR_W-1:0];
    end

    // held instruction copy; memory itself is never written
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            held_instr <= WORD_RST;
        else if (state == OAG_IDLE && start)
            held_instr <= instr;
        else if (state == OAG_WAIT && rd_valid)
            held_instr[MODE_BIT:0] <= rd_data[MODE_BIT:0];
    end

    // level counter shows how far the indirect chain ran
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            indirect_levels <= WORD_RST;
        else if (state == OAG_IDLE && start)
            indirect_levels <= WORD_RST;
        else if (state == OAG_WAIT && rd_valid)
            indirect_levels <= indirect_levels + 24'h000001;
    end

    // result outputs
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            done         <= 1'b0;
            trap         <= 1'b0;
            operand_addr <= 17'h00000;
            next_instruction_fetch_sequence <= 1'b0;
        end else begin
            done <= (state == OAG_INDEX) && !(mode && cur_fmt == OAG_FMT_WORD && indirect_ok);
            if (take && fmt == OAG_FMT_NOADDR && !absent)
                done <= 1'b1;
            trap <= take && absent;
            if (state == OAG_INDEX)
                operand_addr <= use_index ? sum : addr;
            else if (take && fmt == OAG_FMT_NOADDR && !absent)
                operand_addr <= instr[CADDR_W-1:0];
            next_instruction_fetch_sequence <=
                (state == OAG_DONE || state == OAG_TRAP) && instr_complete;
        end
    end
endmodule : oag_top

// ==== sim/oag_chk.sv ====
// assertions on the oag_top ports
// bound to every oag_top instance; one clock domain
`timescale 1ns/1ps
module oag_chk (
    // request side
    input wire logic                       core_clk,
    input wire logic                       rst_b,
    input wire logic                       start,
    input wire logic [oag_pkg::WORD_W-1:0] instr,
    input wire oag_pkg::oag_fmt_t          fmt,
    input wire logic                       indirect_ok,
    input wire logic                       needs_option,
    input wire logic                       option_present,
    input wire logic                       instr_complete,
    // storage and results
    input wire logic                       rd_req,
    input wire logic                       rd_valid,
    input wire logic [oag_pkg::WORD_W-1:0] rd_data,
    input wire logic                       busy,
    input wire logic                       done,
    input wire logic                       trap,
    input wire logic [16:0]                operand_addr,
    input wire logic [oag_pkg::WORD_W-1:0] held_instr,
    input wire logic                       next_instruction_fetch_sequence
);
    import oag_pkg::*;
    logic go;
    assign go = start & ~busy & ~(needs_option & ~option_present);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    trap_absent_a: assert property (start && !busy && needs_option && !option_present
        |=> trap && !done) else $error("missing trap");
    noaddr_op_a: assert property (go && fmt == OAG_FMT_NOADDR
        |=> done && operand_addr == $past(instr[16:0])) else $error("bad no-address operand");
    word_direct_a: assert property (go && fmt == OAG_FMT_WORD && instr[16:15] == 2'b00
        && !(instr[17] && indirect_ok) |=> ##1 done && operand_addr == {2'b00, $past(instr[14:0], 2)})
        else $error("bad direct address");
    fetch_start_a: assert property (go && fmt == OAG_FMT_WORD && instr[17] && indirect_ok
        |=> ##1 rd_req && !done) else $error("no indirect fetch");
    level_more_a: assert property (rd_valid && busy && rd_data[17] |-> ##2 rd_req)
        else $error("no further level");
    level_end_a: assert property (rd_valid && busy && !rd_data[17] |-> !done ##2 done)
        else $error("chain end missed");
    held_copy_a: assert property (rd_valid && busy |=> held_instr[17:0] == $past(rd_data[17:0]))
        else $error("held copy not updated");
    next_fetch_a: assert property (instr_complete |=> next_instruction_fetch_sequence)
        else $error("no next fetch");
endmodule : oag_chk
bind oag_top oag_chk oag_chk_i (.core_clk, .rst_b, .start, .instr, .fmt, .indirect_ok,
    .needs_option, .option_present, .instr_complete, .rd_req, .rd_valid, .rd_data, .busy,
    .done, .trap, .operand_addr, .held_instr, .next_instruction_fetch_sequence);

// ==== sim/oag_mem_model.sv ====
// core storage answering address-word reads
// assumes a one-cycle rd_req; answers alternate prompt and slow
`timescale 1ns/1ps
module oag_mem_model (
    // read port
    input wire logic                        core_clk,
    input wire logic                        rd_req,
    input wire logic [oag_pkg::WADDR_W-1:0] rd_addr,
    output logic                            rd_valid,
    output logic     [oag_pkg::WORD_W-1:0]  rd_data
);
    import oag_pkg::*;
    logic [WORD_W-1:0] mem [0:32767];
    logic [WORD_W-1:0] last;
    logic              slow;
    initial begin
        rd_valid = 1'b0;
        rd_data = 24'h000000;
        slow = 1'b0;
        foreach (mem[i]) mem[i] = 24'h000000;
        forever begin
            @(posedge core_clk);
            if (rd_req === 1'b1) begin
                // read only: no write path, so stored words never change
                last = mem[rd_addr];
                if (slow) repeat (2) @(posedge core_clk);
                slow = ~slow;
                rd_valid <= 1'b1;
                rd_data <= last;
                @(posedge core_clk);
                rd_valid <= 1'b0;
                // released data must not look valid
                rd_data <= ~last;
            end
        end
    end
endmodule : oag_mem_model

// ==== sim/tb.sv ====
// self-checking bench for oag_top with a storage model
// expectations queued by the driver, compared by the monitor
`timescale 1ns/1ps
module tb;
    import oag_pkg::*;
    logic        core_clk, rst_b, start, indirect_ok, needs_option, option_present;
    logic        instr_complete, rd_req, rd_valid, busy, done, trap, nifs;
    logic [23:0] instr, rd_data, held_instr, w, lvl;
    logic [14:0] index1, index2, index3, rd_addr;
    logic [16:0] operand_addr;
    logic [1:0]  bdp_flag;
    oag_fmt_t    fmt;
    logic [65:0] exp_q[$];
    logic [31:0] rng = 32'h9fc45201;
    int          bad_count = 0, cmp_count = 0;
    oag_top oag_top_i (.core_clk(core_clk), .rst_b(rst_b), .start(start), .instr(instr),
        .fmt(fmt), .indirect_ok(indirect_ok), .bdp_flag(bdp_flag), .needs_option(needs_option),
        .option_present(option_present), .instr_complete(instr_complete), .index1(index1),
        .index2(index2), .index3(index3), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data), .busy(busy), .done(done), .trap(trap),
        .operand_addr(operand_addr), .held_instr(held_instr), .indirect_levels(lvl),
        .next_instruction_fetch_sequence(nifs));
    oag_mem_model oag_mem_model_i (.core_clk(core_clk), .rd_req(rd_req), .rd_addr(rd_addr),
        .rd_valid(rd_valid), .rd_data(rd_data));
    function automatic logic [14:0] rnd();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng[14:0];
    endfunction : rnd
    // end-around carry keeps the sum a ones-complement result
    function automatic logic [14:0] oc(input logic [14:0] a, input logic [14:0] b);
        logic [15:0] s;
        s = a + b;
        return s[14:0] + s[15];
    endfunction : oc
    function automatic logic [14:0] ix(input logic [1:0] d);
        return d == 2'd1 ? index1 : d == 2'd2 ? index2 : d == 2'd3 ? index3 : 15'h0000;
    endfunction : ix
    task automatic check(input logic [65:0] seen, input logic [65:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR %0t result %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic run(input oag_fmt_t f, input logic [23:0] v, input logic iok,
        input logic [1:0] fl, input logic nopt, input logic opr);
        logic [23:0] h;
        logic [16:0] a;
        logic [14:0] t;
        logic [23:0] lv;
        int          n;
        @(posedge core_clk);
        {start, instr, indirect_ok, bdp_flag} <= {1'b1, v, iok, fl};
        fmt <= f;
        {needs_option, option_present} <= {nopt, opr};
        index1 <= rnd() | (f == OAG_FMT_BDP ? 15'h0003 : 15'h0000);
        index2 <= rnd() | (f == OAG_FMT_BDP ? 15'h0003 : 15'h0000);
        index3 <= rnd();
        @(posedge core_clk);
        // a second start while busy must be ignored
        start <= (f == OAG_FMT_WORD) && !nopt;
        h = v;
        lv = 24'h000000;
        t = ix(v[18:17]);
        case (f)
            OAG_FMT_NOADDR: a = v[16:0];
            OAG_FMT_CHAR: a = v[16:0] + {{2{t[14]}}, t};
            OAG_FMT_BDP: a = {2'b00, oc(v[14:0], fl == 2'd0 ? 15'h0 : fl == 2'd2 ? index2 : index1)};
            default: begin
                while (h[17] && iok) begin
                    h[17:0] = oag_mem_model_i.mem[oc(h[14:0], ix(h[16:15]))][17:0];
                    lv = lv + 24'h000001;
                end
                a = {2'b00, oc(h[14:0], ix(h[16:15]))};
            end
        endcase
        exp_q.push_back((nopt && !opr) ? {1'b1, 65'h0} : {1'b0, h, a, lv});
        @(posedge core_clk);
        start <= 1'b0;
        n = 0;
        while (done !== 1'b1 && trap !== 1'b1 && n < 60) begin
            @(posedge core_clk);
            n++;
        end
        instr_complete <= 1'b1;
        @(posedge core_clk);
        instr_complete <= 1'b0;
        n = 0;
        while (busy !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
    endtask : run
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : report_and_stop
    always @(posedge core_clk) begin
        if (done === 1'b1 || trap === 1'b1) begin
            check({trap, trap ? 41'h0 : {held_instr, operand_addr}, lvl}, exp_q.pop_front());
        end
    end
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    initial begin
        #100000;
        bad_count++;
        report_and_stop();
    end
    initial begin
        {rst_b, start, instr, indirect_ok, bdp_flag} = '0;
        fmt = OAG_FMT_NOADDR;
        {needs_option, option_present, instr_complete, index1, index2, index3} = '0;
        repeat (10) @(posedge core_clk);
        rst_b <= 1'b1;
        for (int f = 0; f < 4; f++) begin
            for (int d = 0; d < 4; d++) begin
                w = 24'({rnd(), rnd()});
                w[18:15] = {d[1:0], d[1:0]};
                run(oag_fmt_t'(f), w, 1'b0, d[1:0], 1'b0, 1'b0);
            end
        end
        oag_mem_model_i.mem[15'h1234] = {6'h00, 3'b100, 15'h0777};
        oag_mem_model_i.mem[15'h0777] = {6'h00, 3'b001, 15'h0100};
        run(OAG_FMT_WORD, {6'h05, 3'b100, 15'h1234}, 1'b1, 2'd0, 1'b0, 1'b0);
        run(OAG_FMT_WORD, {6'h05, 3'b100, 15'h1234}, 1'b0, 2'd0, 1'b0, 1'b0);
        run(OAG_FMT_NOADDR, 24'({rnd(), rnd()}), 1'b1, 2'd1, 1'b1, 1'b0);
        run(OAG_FMT_CHAR, 24'({rnd(), rnd()}), 1'b0, 2'd2, 1'b1, 1'b1);
        repeat (60) begin
            w = 24'({rnd(), rnd()});
            run(oag_fmt_t'(w[23:22]), w, w[21], w[20:19], w[18], w[17]);
        end
        check({65'h0, exp_q.size() != 0}, 66'h0);
        report_and_stop();
    end
endmodule : tb
